// >>> pkg/dbe_pkg.sv
// Purpose: Shared constants and types for the data bank and nonvolatile write controller
// Assumes: 20 MHz core clock, 8-bit data space with 8-bit addresses
// Notes:   Offsets, field positions, reset values and cycle counts live here only
`default_nettype none
package dbe_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] DBE_BANK_SEL_ADDR = 8'hE8;
    localparam logic [7:0] DBE_NVM_CTL_ADDR = 8'hEA;
    localparam logic [7:0] DBE_BANK_HI_ADDR = 8'h3F;
    localparam logic [7:0] DBE_CTL_RESET = 8'h00;
    localparam logic [7:0] DBE_ZERO_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DBE_RAM2_BIT = 4;
    localparam int DBE_NVM0_BIT = 0;
    localparam int DBE_STANDBY_BIT = 6;
    localparam int DBE_START_BIT = 3;
    localparam int DBE_ROWMODE_BIT = 2;
    localparam int DBE_BUSY_BIT = 1;
    localparam int DBE_WREN_BIT = 0;

    // ------------------------------------------------------------
    // Programming time
    // ------------------------------------------------------------
    localparam int DBE_CLK_HZ = 20_000_000;
    localparam int DBE_PROG_TIME_MS = 5;
    localparam int DBE_PROG_CYCLES = DBE_PROG_TIME_MS * (DBE_CLK_HZ / 1000);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic [7:0][7:0] dbe_row_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dbe_bus_req_s;

    typedef enum logic [3:0] {
        DBE_ST_IDLE = 4'b0001,
        DBE_ST_ROW = 4'b0010,
        DBE_ST_PROG_BYTE = 4'b0100,
        DBE_ST_PROG_ROW = 4'b1000
    } dbe_state_e;

endpackage
`default_nettype wire

// >>> logic/dbe_nvm_cells.sv
// Purpose: 64-byte nonvolatile cell array with a masked row write port
// Assumes: Cell timing is handled by the caller; a commit lands in one edge
// Notes:   Cells have no reset, their contents survive a system reset
`timescale 1ns/1ps
`default_nettype none
module dbe_nvm_cells
    import dbe_pkg::*;
(
    input wire logic sys_clk,
    input wire logic ce,
    input wire logic prog_en,
    input wire logic [2:0] prog_row,
    input wire logic [7:0] prog_mask,
    input wire dbe_row_t prog_data,
    input wire logic [5:0] rd_addr,
    output logic [7:0] rd_data
);

    logic [7:0] cells [64];

    // ------------------------------------------------------------
    // Commit only the bytes flagged in the mask, the rest keep their value
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (ce && prog_en) begin
            for (int i = 0; i < 8; i++) begin
                if (prog_mask[i]) begin
                    cells[{prog_row, 3'(i)}] <= prog_data[i];
                end
            end
        end
    end

    assign rd_data = cells[rd_addr];

endmodule
`default_nettype wire

// >>> logic/dbe_ctrl.sv
// Purpose: Banked data-space window and nonvolatile write control for an 8-bit core
// Assumes: Core drives one request per cycle on sys_clk; read data appears next edge
// Notes:   Bank register is left uncleared by reset; software writes it before use
`timescale 1ns/1ps
`default_nettype none
module dbe_ctrl
    import dbe_pkg::*;
#(
    parameter int PROG_CYCLES = DBE_PROG_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire dbe_bus_req_s bus_req,
    output logic [7:0] cpu_rdata,
    output logic nvm_busy,
    output logic nvm_power_down
);

    localparam int CNT_W = $clog2(PROG_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(PROG_CYCLES - 1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] data_bank_select_r;
    logic [7:0] data_bank_select_nxt;
    logic nvm_standby_r;
    logic nvm_standby_nxt;
    logic nvm_write_enable_r;
    logic nvm_write_enable_nxt;
    dbe_state_e state_r;
    dbe_state_e state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    dbe_row_t lat_r;
    dbe_row_t lat_nxt;
    logic [7:0] mask_r;
    logic [7:0] mask_nxt;
    logic [2:0] row_r;
    logic [2:0] row_nxt;
    logic row_valid_r;
    logic row_valid_nxt;
    logic [7:0] rdata_nxt;
    logic [7:0] ram2_mem [64];

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic in_bank(input logic [7:0] a);
        return a <= DBE_BANK_HI_ADDR;
    endfunction

    wire logic [5:0] page_addr = bus_req.addr[5:0];
    wire logic [2:0] page_row = bus_req.addr[5:3];
    wire logic [2:0] page_col = bus_req.addr[2:0];
    wire logic bank_hit = in_bank(bus_req.addr);
    wire logic ram2_sel = data_bank_select_r[DBE_RAM2_BIT];
    wire logic nvm_sel = data_bank_select_r[DBE_NVM0_BIT];
    wire logic busy = (state_r == DBE_ST_PROG_BYTE) || (state_r == DBE_ST_PROG_ROW);
    wire logic row_mode = (state_r == DBE_ST_ROW) || (state_r == DBE_ST_PROG_ROW);
    wire logic start_bit = (state_r == DBE_ST_PROG_ROW);
    wire logic bank_wr = bus_req.wr && (bus_req.addr == DBE_BANK_SEL_ADDR);
    wire logic ctl_wr = bus_req.wr && (bus_req.addr == DBE_NVM_CTL_ADDR);
    wire logic ctl_rd = bus_req.rd && (bus_req.addr == DBE_NVM_CTL_ADDR);
    wire logic ctl_wr_ok = ctl_wr && !busy;
    // Standby and busy both kill nonvolatile page accesses without a trace; second RAM page accesses still go through
    wire logic nvm_live = nvm_sel && bank_hit && !nvm_standby_r && !busy;
    wire logic row_ok = !row_mode || !row_valid_r || (row_r == page_row);
    wire logic nvm_wr_ok = bus_req.wr && nvm_live && row_ok;
    wire logic nvm_rd_ok = bus_req.rd && nvm_live && row_ok;
    wire logic ram2_wr = bus_req.wr && bank_hit && ram2_sel;
    wire logic ram2_rd = bus_req.rd && bank_hit && ram2_sel;
    wire logic prog_done = busy && (cnt_r == '0);
    wire logic row_start = ctl_wr_ok && (state_r == DBE_ST_ROW)
                           && bus_req.wdata[DBE_START_BIT] && bus_req.wdata[DBE_ROWMODE_BIT]
                           && bus_req.wdata[DBE_WREN_BIT];
    wire logic byte_start = nvm_wr_ok && (state_r == DBE_ST_IDLE) && nvm_write_enable_r;
    wire logic [7:0] ram2_q = ram2_mem[page_addr];
    wire logic [7:0] nvm_q;
    wire logic [7:0] ctl_status = {6'h00, busy, 1'b0};
    wire logic [7:0] prog_mask = mask_r;

    // ------------------------------------------------------------
    // Cell array
    // ------------------------------------------------------------
    dbe_nvm_cells u_cells (
        .sys_clk(sys_clk),
        .ce(ce),
        .prog_en(prog_done),
        .prog_row(row_r),
        .prog_mask(prog_mask),
        .prog_data(lat_r),
        .rd_addr(page_addr),
        .rd_data(nvm_q)
    );

    // ------------------------------------------------------------
    // Control and row latch next state
    // ------------------------------------------------------------
    always_comb begin
        data_bank_select_nxt = data_bank_select_r;
        nvm_standby_nxt = nvm_standby_r;
        nvm_write_enable_nxt = nvm_write_enable_r;
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        lat_nxt = lat_r;
        mask_nxt = mask_r;
        row_nxt = row_r;
        row_valid_nxt = row_valid_r;
        // Whole byte stored; the register has no read path to merge bits from
        if (bank_wr) begin
            data_bank_select_nxt = bus_req.wdata;
        end
        if (ctl_wr_ok) begin
            nvm_standby_nxt = bus_req.wdata[DBE_STANDBY_BIT];
            nvm_write_enable_nxt = bus_req.wdata[DBE_WREN_BIT];
        end
        case (state_r)
            DBE_ST_IDLE: begin
                if (ctl_wr_ok && bus_req.wdata[DBE_ROWMODE_BIT]) begin
                    state_nxt = DBE_ST_ROW;
                    mask_nxt = 8'h00;
                    row_valid_nxt = 1'b0;
                end else if (byte_start) begin
                    // Byte goes straight into one latch slot and commits alone
                    state_nxt = DBE_ST_PROG_BYTE;
                    cnt_nxt = CNT_LOAD;
                    lat_nxt[page_col] = bus_req.wdata;
                    mask_nxt = 8'(1 << page_col);
                    row_nxt = page_row;
                end
            end
            DBE_ST_ROW: begin
                if (ctl_wr_ok && !bus_req.wdata[DBE_ROWMODE_BIT]) begin
                    state_nxt = DBE_ST_IDLE;
                    mask_nxt = 8'h00;
                    row_valid_nxt = 1'b0;
                end else if (row_start) begin
                    state_nxt = DBE_ST_PROG_ROW;
                    cnt_nxt = CNT_LOAD;
                end else if (nvm_wr_ok) begin
                    lat_nxt[page_col] = bus_req.wdata;
                    mask_nxt[page_col] = 1'b1;
                    row_nxt = page_row;
                    row_valid_nxt = 1'b1;
                end
            end
            DBE_ST_PROG_BYTE, DBE_ST_PROG_ROW: begin
                if (prog_done) begin
                    state_nxt = DBE_ST_IDLE;
                    mask_nxt = 8'h00;
                    row_valid_nxt = 1'b0;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: begin
                state_nxt = DBE_ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = DBE_ZERO_BYTE;
        if (ctl_rd) begin
            rdata_nxt = ctl_status;
        end else if (bus_req.rd && bank_hit) begin
            // Two enabled pages overlap on the bus, as they would in silicon
            rdata_nxt = (ram2_rd ? ram2_q : DBE_ZERO_BYTE)
                        | (nvm_rd_ok ? nvm_q : DBE_ZERO_BYTE);
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // No reset and no save/restore path on the bank register
    always_ff @(posedge sys_clk) begin
        if (ce) begin
            data_bank_select_r <= data_bank_select_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            nvm_standby_r <= DBE_CTL_RESET[DBE_STANDBY_BIT];
            nvm_write_enable_r <= DBE_CTL_RESET[DBE_WREN_BIT];
            state_r <= DBE_ST_IDLE;
            cnt_r <= '0;
            mask_r <= 8'h00;
            row_valid_r <= 1'b0;
            cpu_rdata <= DBE_ZERO_BYTE;
        end else if (ce) begin
            nvm_standby_r <= nvm_standby_nxt;
            nvm_write_enable_r <= nvm_write_enable_nxt;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            mask_r <= mask_nxt;
            row_valid_r <= row_valid_nxt;
            cpu_rdata <= rdata_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ce) begin
            lat_r <= lat_nxt;
            row_r <= row_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ce && ram2_wr) begin
            ram2_mem[page_addr] <= bus_req.wdata;
        end
    end

    assign nvm_busy = busy;
    assign nvm_power_down = nvm_standby_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_row_go;
        ce && row_start;
    endsequence

    sequence s_prog_end;
        ce && prog_done;
    endsequence

    // Counts busy cycles so the whole duration is checked, not only a prefix
    logic [CNT_W-1:0] busy_cnt_r;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            busy_cnt_r <= '0;
        end else if (ce) begin
            busy_cnt_r <= busy ? busy_cnt_r + 1'b1 : '0;
        end
    end

    chk_bank_store: assert property (@(posedge sys_clk) disable iff (!resetn)
        ce && bank_wr |=> data_bank_select_r == $past(bus_req.wdata))
        else $error("bank select not stored");

    chk_bank_rd_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
        ce && bus_req.rd && bus_req.addr == DBE_BANK_SEL_ADDR |=> cpu_rdata == 8'h00)
        else $error("bank select readable");

    chk_ram2_route: assert property (@(posedge sys_clk) disable iff (!resetn)
        ce && ram2_rd && !nvm_sel |=> cpu_rdata == $past(ram2_q))
        else $error("second RAM page not routed");

    chk_busy_read: assert property (@(posedge sys_clk) disable iff (!resetn)
        ce && ctl_rd && busy |=> cpu_rdata == 8'h02)
        else $error("busy status not readable");

    chk_ctl_frozen: assert property (@(posedge sys_clk) disable iff (!resetn)
        ce && ctl_wr && busy |=> nvm_write_enable_r == $past(nvm_write_enable_r)
                                 && nvm_standby_r == $past(nvm_standby_r))
        else $error("control changed while busy");

    chk_no_wren_prog: assert property (@(posedge sys_clk) disable iff (!resetn)
        ce && state_r == DBE_ST_IDLE && bus_req.wr && bank_hit && !nvm_write_enable_r
        |=> !busy)
        else $error("programming started without write enable");

    chk_start_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
        ce && ctl_wr_ok && bus_req.wdata[DBE_START_BIT]
        && !(bus_req.wdata[DBE_WREN_BIT] && row_mode) |=> !start_bit)
        else $error("start accepted without enable and row mode");

    chk_busy_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_row_go |=> busy [*8])
        else $error("busy dropped early");

    chk_busy_length: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_prog_end |-> busy_cnt_r == CNT_LOAD)
        else $error("busy length differs from programming count");

    chk_end_clears: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_prog_end |=> !row_mode && !start_bit && !busy && mask_r == 8'h00)
        else $error("cycle end left row mode set");

    chk_latch_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
        ce && ctl_wr_ok && state_r == DBE_ST_IDLE && bus_req.wdata[DBE_ROWMODE_BIT]
        |=> mask_r == 8'h00 && row_mode)
        else $error("row latches not cleared on entry");

    chk_abandon: assert property (@(posedge sys_clk) disable iff (!resetn)
        ce && ctl_wr_ok && state_r == DBE_ST_ROW && !bus_req.wdata[DBE_ROWMODE_BIT]
        |=> mask_r == 8'h00 && !busy)
        else $error("row not abandoned");

    chk_standby_read: assert property (@(posedge sys_clk) disable iff (!resetn)
        ce && bus_req.rd && bank_hit && nvm_standby_r && !ram2_sel |=> cpu_rdata == 8'h00)
        else $error("page read while in standby");

endmodule
`default_nettype wire

// >>> testbench/dbe_cpu_model.sv
// Purpose: Core-side model issuing one data-space request at a time
// Assumes: Requests are taken on the first rising edge after they are driven
// Notes:   Released address and data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module dbe_cpu_model
    import dbe_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [7:0] cpu_rdata,
    output var dbe_bus_req_s bus_req
);
    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    initial begin
        bus_req = '{wr: 1'b0, rd: 1'b0, addr: 8'hFF, wdata: 8'hFF};
    end

    // Stale lines are inverted so a late sample can never match by luck
    task automatic release_bus();
        bus_req.wr = 1'b0;
        bus_req.rd = 1'b0;
        bus_req.addr = ~bus_req.addr;
        bus_req.wdata = ~bus_req.wdata;
    endtask

    // Whole-byte writes only, never read-modify-write of write-only places
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        #1;
        bus_req.addr = addr;
        bus_req.wdata = data;
        bus_req.wr = 1'b1;
        @(posedge sys_clk);
        #1;
        release_bus();
    endtask

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge sys_clk);
        #1;
        bus_req.addr = addr;
        bus_req.rd = 1'b1;
        @(posedge sys_clk);
        #1;
        data = cpu_rdata;
        release_bus();
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Purpose: Self-checking bench for the banked window and nonvolatile write control
// Assumes: Programming time shortened to 20 cycles; clock enable held high except during the clock enable test
// Notes:   Unwritten cells are unknown, so only bytes written here are compared
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dbe_pkg::*;
    localparam int PROG = 20;
    localparam int LIMIT = 4000;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    dbe_bus_req_s bus_req;
    logic [7:0] cpu_rdata;
    logic nvm_busy;
    logic nvm_power_down;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;
    int n;
    logic [7:0] no_page [4] = '{8'h00, 8'h02, 8'h08, 8'h20};
    logic [7:0] row_a [5] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h20};
    logic [7:0] row_d [5] = '{8'h11, 8'hC3, 8'h22, 8'h33, 8'h5C};

    always #25 sys_clk = ~sys_clk;

    dbe_ctrl #(.PROG_CYCLES(PROG)) dbe_ctrl_inst (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ce(ce),
        .bus_req(bus_req),
        .cpu_rdata(cpu_rdata),
        .nvm_busy(nvm_busy),
        .nvm_power_down(nvm_power_down)
    );

    dbe_cpu_model dbe_cpu_model_inst (
        .sys_clk(sys_clk),
        .cpu_rdata(cpu_rdata),
        .bus_req(bus_req)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            $display("timeout at %0t", $time);
            n_fail++;
            end_of_test();
        end
    end

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        dbe_cpu_model_inst.wr(a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        dbe_cpu_model_inst.rd(a, v);
        cmp_byte(v, exp);
    endtask

    // Waits a few cycles for a cycle to begin, then counts its busy cycles
    task automatic busy_len(output int len);
        len = 0;
        for (int i = 0; i < 4 && nvm_busy !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        while (nvm_busy === 1'b1 && len < 200) begin
            len++;
            @(posedge sys_clk);
            #1;
        end
    endtask

    task automatic test_done(input string name);
        $display("test %s done, checks %0d, n_fail %0d", name, checks, n_fail);
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        cmp_bit(nvm_busy, 1'b0);
        cmp_bit(nvm_power_down, 1'b0);
        rd_chk(DBE_NVM_CTL_ADDR, DBE_CTL_RESET);
        test_done("reset");

        wr(DBE_BANK_SEL_ADDR, 8'h10);
        rd_chk(DBE_BANK_SEL_ADDR, 8'h00);
        wr(8'h05, 8'h5A);
        wr(DBE_BANK_HI_ADDR, 8'hC6);
        rd_chk(8'h05, 8'h5A);
        rd_chk(DBE_BANK_HI_ADDR, 8'hC6);
        rd_chk(8'h45, 8'h00);
        foreach (no_page[i]) begin
            wr(DBE_BANK_SEL_ADDR, no_page[i]);
            rd_chk(8'h05, 8'h00);
        end
        test_done("bank");

        wr(DBE_NVM_CTL_ADDR, 8'h01);
        wr(DBE_BANK_SEL_ADDR, 8'h01);
        wr(8'h05, 8'hA5);
        busy_len(n);
        cmp_byte(8'(n), 8'(PROG));
        rd_chk(8'h05, 8'hA5);
        wr(8'h20, 8'h5C);
        rd_chk(DBE_NVM_CTL_ADDR, 8'h02);
        wr(DBE_NVM_CTL_ADDR, 8'h40);
        cmp_bit(nvm_power_down, 1'b0);
        rd_chk(8'h05, 8'h00);
        busy_len(n);
        rd_chk(8'h20, 8'h5C);
        wr(8'h19, 8'hC3);
        busy_len(n);
        cmp_byte(8'(n), 8'(PROG));
        wr(DBE_NVM_CTL_ADDR, 8'h00);
        wr(8'h05, 8'h11);
        busy_len(n);
        cmp_byte(8'(n), 8'h00);
        rd_chk(8'h05, 8'hA5);
        test_done("byte");

        wr(DBE_NVM_CTL_ADDR, 8'h05);
        wr(8'h18, 8'h11);
        wr(8'h1A, 8'h22);
        wr(8'h1B, 8'h33);
        wr(8'h20, 8'h44);
        wr(DBE_NVM_CTL_ADDR, 8'h0D);
        busy_len(n);
        cmp_byte(8'(n), 8'(PROG));
        foreach (row_a[i]) begin
            rd_chk(row_a[i], row_d[i]);
        end
        wr(DBE_NVM_CTL_ADDR, 8'h0D);
        busy_len(n);
        cmp_byte(8'(n), 8'h00);
        wr(8'h18, 8'h99);
        wr(DBE_NVM_CTL_ADDR, 8'h01);
        busy_len(n);
        cmp_byte(8'(n), 8'h00);
        rd_chk(8'h18, 8'h11);
        wr(DBE_NVM_CTL_ADDR, 8'h04);
        wr(8'h18, 8'h77);
        wr(DBE_NVM_CTL_ADDR, 8'h0C);
        busy_len(n);
        cmp_byte(8'(n), 8'h00);
        wr(DBE_NVM_CTL_ADDR, 8'h00);
        rd_chk(8'h18, 8'h11);
        test_done("row");

        wr(DBE_NVM_CTL_ADDR, 8'h41);
        cmp_bit(nvm_power_down, 1'b1);
        rd_chk(8'h05, 8'h00);
        wr(8'h05, 8'h77);
        busy_len(n);
        cmp_byte(8'(n), 8'h00);
        wr(DBE_NVM_CTL_ADDR, 8'h00);
        cmp_bit(nvm_power_down, 1'b0);
        rd_chk(8'h05, 8'hA5);
        test_done("standby");

        // A request offered while the clock enable is low must not be taken
        ce = 1'b0;
        wr(DBE_NVM_CTL_ADDR, 8'h40);
        ce = 1'b1;
        cmp_bit(nvm_power_down, 1'b0);
        test_done("clock enable");

        // Bank choice must survive a reset; software is not forced to rewrite it
        wr(DBE_BANK_SEL_ADDR, 8'h10);
        resetn = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        rd_chk(8'h05, 8'h5A);
        rd_chk(DBE_NVM_CTL_ADDR, DBE_CTL_RESET);
        test_done("second reset");
        end_of_test();
    end
endmodule
`default_nettype wire
